// ==== src/payload_extras_pkg.sv ====
// package: register map, block selector codes, widths and reset values
// assumes: one image clock domain, plain register port on the main module
package payload_extras_pkg;

  localparam int unsigned ADDR_WIDTH = 6;
  localparam int unsigned DATA_WIDTH = 32;
  localparam int unsigned BLOCK_COUNT = 15;
  localparam int unsigned SERIAL_DEPTH = 16;
  localparam int unsigned SERIAL_IDX_WIDTH = 4;
  localparam int unsigned SERIAL_CNT_WIDTH = 5;
  localparam int unsigned LINE_WIDTH = 4;

  // register offsets (byte addresses)
  localparam logic [ADDR_WIDTH-1:0] OFS_EXTRAS_ON = 6'h00;
  localparam logic [ADDR_WIDTH-1:0] OFS_BLOCK_PICK = 6'h04;
  localparam logic [ADDR_WIDTH-1:0] OFS_BLOCK_INCLUDE = 6'h08;
  localparam logic [ADDR_WIDTH-1:0] OFS_INCLUDE_ALL = 6'h0C;
  localparam logic [ADDR_WIDTH-1:0] OFS_AMP_PICK = 6'h10;
  localparam logic [ADDR_WIDTH-1:0] OFS_DARK_PICK = 6'h14;
  localparam logic [ADDR_WIDTH-1:0] OFS_STATUS = 6'h18;
  localparam logic [ADDR_WIDTH-1:0] OFS_IRQ_STATUS = 6'h1C;
  localparam logic [ADDR_WIDTH-1:0] OFS_IRQ_MASK = 6'h20;
  localparam logic [ADDR_WIDTH-1:0] OFS_LAST_CHECK = 6'h24;
  localparam logic [ADDR_WIDTH-1:0] OFS_LAST_FRAME = 6'h28;

  // status register bit positions
  localparam int unsigned STAT_ACQ_BIT = 0;
  localparam int unsigned STAT_OVERRUN_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT = 2;

  // interrupt bit positions
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_REFUSED_BIT = 1;
  localparam int unsigned IRQ_OVERRUN_BIT = 2;
  localparam int unsigned IRQ_WIDTH = 3;

  // selector codes, in append order
  localparam logic [3:0] SEL_IMAGE = 4'h0;
  localparam logic [3:0] SEL_CHECK = 4'h1;
  localparam logic [3:0] SEL_FRAME = 4'h2;
  localparam logic [3:0] SEL_X_START = 4'h3;
  localparam logic [3:0] SEL_Y_START = 4'h4;
  localparam logic [3:0] SEL_COLUMNS = 4'h5;
  localparam logic [3:0] SEL_ROWS = 4'h6;
  localparam logic [3:0] SEL_INTEGRATION = 4'h7;
  localparam logic [3:0] SEL_AMPLIFICATION = 4'h8;
  localparam logic [3:0] SEL_DARK_OFFSET = 4'h9;
  localparam logic [3:0] SEL_LAYOUT = 4'hA;
  localparam logic [3:0] SEL_TIME_STAMP = 4'hB;
  localparam logic [3:0] SEL_SEQUENCE = 4'hC;
  localparam logic [3:0] SEL_SERIAL = 4'hD;
  localparam logic [3:0] SEL_LINES = 4'hE;
  localparam logic [3:0] SEL_LAST = 4'hE;

  // reset values: only image and check blocks included
  localparam logic [BLOCK_COUNT-1:0] FORCED_INCLUDE = 15'h0003;
  localparam logic [BLOCK_COUNT-1:0] INCLUDE_RESET = 15'h0003;

  // crc-32 reflected polynomial and seeds
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_SEED = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_XOR_OUT = 32'hFFFFFFFF;

  // gain pick codes
  localparam logic [1:0] AMP_ALL = 2'h0;
  localparam logic [1:0] AMP_RED = 2'h1;
  localparam logic [1:0] AMP_GREEN = 2'h2;
  localparam logic [1:0] AMP_BLUE = 2'h3;

endpackage

// ==== src/payload_check_crc.sv ====
// crc-32 engine over a 32-bit word stream
// assumes: clear and word strobes never together
`timescale 1ns/100ps
`default_nettype none

module payload_check_crc
  import payload_extras_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        clear_in,
  input  wire logic        word_valid_in,
  input  wire logic [31:0] word_in,
  output logic [31:0]      check_out
);

  logic [31:0] state_reg;
  logic [31:0] state_next;

  // ===
  // bitwise reflected update, low bit first
  always_comb
  begin
    state_next = state_reg;
    for (int i = 0; i < 32; i++)
    begin
      if (state_next[0] ^ word_in[i])
        state_next = (state_next >> 1) ^ CRC_POLY;
      else
        state_next = state_next >> 1;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in || clear_in)
      state_reg <= CRC_SEED;
    else if (word_valid_in)
      state_reg <= state_next;
  end

  assign check_out = state_reg ^ CRC_XOR_OUT;

endmodule

`default_nettype wire

// ==== src/image_payload_metadata_appender.sv ====
// image payload framer that appends metadata blocks after the image words
// assumes: image words arrive as a valid stream with a last flag, sink never stalls,
//          captured values are stable from frame start until frame end
//
// Notes on behaviour
// RULE_01: activate on appends enabled blocks, else none
// RULE_02: image and check blocks always included
// RULE_03: fifteen-way selector with per-block include flag
// RULE_04: settings locked while acquisition runs; code locks only activate and include writes
// RULE_05: checksum over image placed in check block
// RULE_06: frame number block carries image frame number
// RULE_07: region blocks carry geometry applied to image
// RULE_08: exposure, gain, dark offset of capture reported
// RULE_09: time stamp and sequence index blocks
// RULE_10: lines sampled together at integration end
// RULE_11: serial bytes, count and overrun flag reported
// RULE_12: crc-32 reflected; blocks appended in selector order
// RULE_13: reset clears activate and optional includes
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module image_payload_metadata_appender
  import payload_extras_pkg::*;
(
  input  wire logic                  mclk_in,
  input  wire logic                  rst_n_in,
  input  wire logic [ADDR_WIDTH-1:0] reg_addr_in,
  input  wire logic [31:0]           reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic [31:0]                reg_rdata_out,
  input  wire logic                  acq_running_in,
  input  wire logic                  pix_valid_in,
  input  wire logic [31:0]           pix_data_in,
  input  wire logic                  pix_last_in,
  input  wire logic [31:0]           frame_sequence_number_in,
  input  wire logic [31:0]           region_x_start_in,
  input  wire logic [31:0]           region_y_start_in,
  input  wire logic [31:0]           region_columns_in,
  input  wire logic [31:0]           region_rows_in,
  input  wire logic [31:0]           integration_duration_in,
  input  wire logic [31:0]           amp_all_in,
  input  wire logic [31:0]           amp_red_in,
  input  wire logic [31:0]           amp_green_in,
  input  wire logic [31:0]           amp_blue_in,
  input  wire logic [31:0]           dark_offset_value_in,
  input  wire logic [31:0]           sample_layout_code_in,
  input  wire logic [31:0]           capture_time_stamp_in,
  input  wire logic [31:0]           running_sequence_index_in,
  input  wire logic                  integration_end_in,
  input  wire logic [LINE_WIDTH-1:0] io_lines_in,
  input  wire logic                  serial_valid_in,
  input  wire logic [7:0]            serial_byte_in,
  output logic                       out_valid_out,
  output logic [31:0]                out_data_out,
  output logic                       out_last_out,
  output logic                       irq_out
);

  typedef enum logic [1:0] {ST_IDLE, ST_IMAGE, ST_EXTRA, ST_SERIAL} phase_type;

  phase_type                   phase_reg;
  logic                        extras_on_reg;
  logic [3:0]                  block_pick_reg;
  logic [BLOCK_COUNT-1:0]      include_reg;
  logic [BLOCK_COUNT-1:0]      frame_include_reg;
  logic                        frame_extras_reg;
  logic [1:0]                  amp_pick_reg;
  logic                        dark_pick_reg;
  logic [IRQ_WIDTH-1:0]        irq_status_reg;
  logic [IRQ_WIDTH-1:0]        irq_mask_reg;
  logic [IRQ_WIDTH-1:0]        irq_event;
  logic [3:0]                  emit_sel_reg;
  logic [SERIAL_IDX_WIDTH-1:0] ser_idx_reg;
  logic [7:0]                  ser_mem [SERIAL_DEPTH];
  logic [SERIAL_CNT_WIDTH-1:0] ser_count_reg;
  logic                        overrun_reg;
  logic [LINE_WIDTH-1:0]       lines_reg;
  logic [31:0]                 last_check_reg;
  logic [31:0]                 last_frame_reg;
  logic [31:0]                 crc_value;
  logic                        crc_clear;
  logic                        cfg_write;
  logic                        refused;
  logic [31:0]                 block_word;
  logic [3:0]                  next_sel;
  logic                        has_next;
  logic [31:0]                 read_word;

  // ===
  // register writes
  assign cfg_write = reg_wr_in && (reg_addr_in == OFS_EXTRAS_ON
                     || reg_addr_in == OFS_BLOCK_INCLUDE || reg_addr_in == OFS_INCLUDE_ALL);
  // RULE_04: lock while running
  assign refused = cfg_write && acq_running_in;

  // RULE_13: activate off at reset
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      extras_on_reg <= 1'b0;
    // RULE_01: global activate write
    else if (reg_wr_in && reg_addr_in == OFS_EXTRAS_ON && !acq_running_in)
      extras_on_reg <= reg_wdata_in[0];
  end

  // RULE_03: selector holds fifteen choices
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      block_pick_reg <= SEL_IMAGE;
    else if (reg_wr_in && reg_addr_in == OFS_BLOCK_PICK && reg_wdata_in[3:0] <= SEL_LAST)
      block_pick_reg <= reg_wdata_in[3:0];
  end

  // RULE_13: optional includes cleared
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      include_reg <= INCLUDE_RESET;
    else if (reg_wr_in && !acq_running_in && reg_addr_in == OFS_BLOCK_INCLUDE)
      // RULE_02: forced blocks stay on
      include_reg <= (include_reg & ~(15'h0001 << block_pick_reg))
                     | ({14'h0000, reg_wdata_in[0]} << block_pick_reg) | FORCED_INCLUDE;
    else if (reg_wr_in && !acq_running_in && reg_addr_in == OFS_INCLUDE_ALL)
      include_reg <= reg_wdata_in[BLOCK_COUNT-1:0] | FORCED_INCLUDE;
  end

  // RULE_08: gain pick; a dark offset pick write always loads 0
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      amp_pick_reg  <= AMP_ALL;
      dark_pick_reg <= 1'b0;
    end
    else if (reg_wr_in && reg_addr_in == OFS_AMP_PICK)
      amp_pick_reg <= reg_wdata_in[1:0];
    else if (reg_wr_in && reg_addr_in == OFS_DARK_PICK)
      dark_pick_reg <= 1'b0;
  end

  // ===
  // interrupts: sticky, write one to clear, set wins
  assign irq_event[IRQ_DONE_BIT]    = out_valid_out && out_last_out;
  assign irq_event[IRQ_REFUSED_BIT] = refused;
  assign irq_event[IRQ_OVERRUN_BIT] = serial_valid_in && ser_count_reg == SERIAL_DEPTH;

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      irq_status_reg <= '0;
    else if (reg_wr_in && reg_addr_in == OFS_IRQ_STATUS)
      irq_status_reg <= (irq_status_reg & ~reg_wdata_in[IRQ_WIDTH-1:0]) | irq_event;
    else
      irq_status_reg <= irq_status_reg | irq_event;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      irq_mask_reg <= '0;
    else if (reg_wr_in && reg_addr_in == OFS_IRQ_MASK)
      irq_mask_reg <= reg_wdata_in[IRQ_WIDTH-1:0];
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(irq_status_reg & irq_mask_reg);
  end

  // ===
  // register reads
  always_comb
  begin
    read_word = 32'h0000_0000;
    unique case (reg_addr_in)
      OFS_EXTRAS_ON:     read_word[0] = extras_on_reg;
      OFS_BLOCK_PICK:    read_word[3:0] = block_pick_reg;
      OFS_BLOCK_INCLUDE: read_word[0] = include_reg[block_pick_reg];
      OFS_INCLUDE_ALL:   read_word[BLOCK_COUNT-1:0] = include_reg;
      OFS_AMP_PICK:      read_word[1:0] = amp_pick_reg;
      OFS_DARK_PICK:     read_word[0] = dark_pick_reg;
      OFS_STATUS:
      begin
        read_word[STAT_ACQ_BIT]     = acq_running_in;
        read_word[STAT_OVERRUN_BIT] = overrun_reg;
        read_word[STAT_BUSY_BIT]    = phase_reg != ST_IDLE;
      end
      OFS_IRQ_STATUS:    read_word[IRQ_WIDTH-1:0] = irq_status_reg;
      OFS_IRQ_MASK:      read_word[IRQ_WIDTH-1:0] = irq_mask_reg;
      OFS_LAST_CHECK:    read_word = last_check_reg;
      OFS_LAST_FRAME:    read_word = last_frame_reg;
      default:           read_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_rd_in)
      reg_rdata_out <= read_word;
    else
      reg_rdata_out <= 32'h0000_0000;
  end

  // ===
  // captured values
  // RULE_10: lines sampled together
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      lines_reg <= '0;
    else if (integration_end_in)
      lines_reg <= io_lines_in;
  end

  // RULE_11: serial byte store and overrun
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      ser_count_reg <= '0;
      overrun_reg   <= 1'b0;
    end
    else if (phase_reg == ST_IDLE && pix_valid_in)
    begin
      ser_count_reg <= '0;
      overrun_reg   <= 1'b0;
    end
    else if (serial_valid_in && phase_reg != ST_SERIAL)
    begin
      if (ser_count_reg == SERIAL_DEPTH)
        overrun_reg <= 1'b1;
      else
        ser_count_reg <= ser_count_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (serial_valid_in && ser_count_reg < SERIAL_DEPTH && phase_reg != ST_SERIAL)
      ser_mem[ser_count_reg[SERIAL_IDX_WIDTH-1:0]] <= serial_byte_in;
  end

  // ===
  // checksum engine
  assign crc_clear = phase_reg == ST_IDLE && pix_valid_in;

  // RULE_05: checksum over image words
  payload_check_crc u_crc (
    .mclk_in       (mclk_in),
    .rst_n_in      (rst_n_in),
    .clear_in      (crc_clear),
    .word_valid_in (pix_valid_in && phase_reg == ST_IMAGE),
    .word_in       (pix_data_in),
    .check_out     (crc_value)
  );

  // ===
  // block word select
  always_comb
  begin
    block_word = 32'h0000_0000;
    unique case (emit_sel_reg)
      SEL_CHECK:       block_word = crc_value;
      // RULE_06: frame number
      SEL_FRAME:       block_word = frame_sequence_number_in;
      // RULE_07: region geometry
      SEL_X_START:     block_word = region_x_start_in;
      SEL_Y_START:     block_word = region_y_start_in;
      SEL_COLUMNS:     block_word = region_columns_in;
      SEL_ROWS:        block_word = region_rows_in;
      // RULE_08: capture settings reported
      SEL_INTEGRATION: block_word = integration_duration_in;
      SEL_AMPLIFICATION:
        unique case (amp_pick_reg)
          AMP_ALL:   block_word = amp_all_in;
          AMP_RED:   block_word = amp_red_in;
          AMP_GREEN: block_word = amp_green_in;
          AMP_BLUE:  block_word = amp_blue_in;
        endcase
      SEL_DARK_OFFSET: block_word = dark_offset_value_in;
      SEL_LAYOUT:      block_word = sample_layout_code_in;
      // RULE_09: time stamp and sequence
      SEL_TIME_STAMP:  block_word = capture_time_stamp_in;
      SEL_SEQUENCE:    block_word = running_sequence_index_in;
      SEL_SERIAL:      block_word = {overrun_reg, 26'h0000000, ser_count_reg};
      SEL_LINES:       block_word = {{(32-LINE_WIDTH){1'b0}}, lines_reg};
      default:         block_word = 32'h0000_0000;
    endcase
  end

  // RULE_12: next included block in order
  always_comb
  begin
    next_sel = SEL_LAST;
    has_next = 1'b0;
    for (int i = BLOCK_COUNT - 1; i > 0; i--)
    begin
      if (frame_include_reg[i] && 4'(i) > emit_sel_reg)
      begin
        next_sel = 4'(i);
        has_next = 1'b1;
      end
    end
  end

  // ===
  // framer
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      phase_reg         <= ST_IDLE;
      emit_sel_reg      <= SEL_IMAGE;
      ser_idx_reg       <= '0;
      frame_include_reg <= INCLUDE_RESET;
      frame_extras_reg  <= 1'b0;
      out_valid_out     <= 1'b0;
      out_data_out      <= 32'h0000_0000;
      out_last_out      <= 1'b0;
      last_check_reg    <= 32'h0000_0000;
      last_frame_reg    <= 32'h0000_0000;
    end
    else
    begin
      out_valid_out <= 1'b0;
      out_last_out  <= 1'b0;
      unique case (phase_reg)
        ST_IDLE:
          if (pix_valid_in)
          begin
            frame_include_reg <= include_reg;
            frame_extras_reg  <= extras_on_reg;
            phase_reg         <= ST_IMAGE;
          end
        ST_IMAGE:
          if (pix_valid_in)
          begin
            out_valid_out <= 1'b1;
            out_data_out  <= pix_data_in;
            if (pix_last_in)
            begin
              last_frame_reg <= frame_sequence_number_in;
              // RULE_01: no extras when off
              if (frame_extras_reg)
              begin
                emit_sel_reg <= SEL_IMAGE;
                phase_reg    <= ST_EXTRA;
              end
              else
              begin
                out_last_out <= 1'b1;
                phase_reg    <= ST_IDLE;
              end
            end
          end
        ST_EXTRA:
        begin
          emit_sel_reg <= next_sel;
          if (emit_sel_reg != SEL_IMAGE)
          begin
            out_valid_out <= 1'b1;
            out_data_out  <= block_word;
            if (emit_sel_reg == SEL_CHECK)
              last_check_reg <= crc_value;
          end
          if (emit_sel_reg == SEL_SERIAL && ser_count_reg != '0)
          begin
            ser_idx_reg <= '0;
            phase_reg   <= ST_SERIAL;
          end
          else if (!has_next && emit_sel_reg != SEL_IMAGE)
          begin
            out_last_out <= 1'b1;
            phase_reg    <= ST_IDLE;
          end
        end
        ST_SERIAL:
        begin
          // RULE_11: received bytes, one per word
          out_valid_out <= 1'b1;
          out_data_out  <= {24'h000000, ser_mem[ser_idx_reg]};
          ser_idx_reg   <= ser_idx_reg + 1'b1;
          if ({1'b0, ser_idx_reg} == ser_count_reg - 1'b1)
          begin
            if (!frame_include_reg[emit_sel_reg])
            begin
              out_last_out <= 1'b1;
              phase_reg    <= ST_IDLE;
            end
            else
              phase_reg <= ST_EXTRA;
          end
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== testbench/payload_extras_chk.sv ====
// checker: stream and register relations at the framer ports
// assumes: bound to the framer, one clock, sink never stalls
`timescale 1ns/100ps
`default_nettype none
module payload_extras_chk
  import payload_extras_pkg::*;
(
  input wire logic                  mclk_in,
  input wire logic                  rst_n_in,
  input wire logic [ADDR_WIDTH-1:0] reg_addr_in,
  input wire logic [31:0]           reg_wdata_in,
  input wire logic                  reg_wr_in,
  input wire logic                  reg_rd_in,
  input wire logic [31:0]           reg_rdata_out,
  input wire logic                  acq_running_in,
  input wire logic                  pix_valid_in,
  input wire logic [31:0]           pix_data_in,
  input wire logic                  pix_last_in,
  input wire logic                  out_valid_out,
  input wire logic [31:0]           out_data_out,
  input wire logic                  out_last_out,
  input wire logic                  irq_out
);
  // ===
  // helper state
  logic       frame_reg;
  logic       image_reg;
  logic       act_reg;
  logic       act_lat_reg;
  logic [2:0] mask_reg;
  wire logic  start_w = pix_valid_in && !frame_reg;

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      frame_reg   <= 1'b0;
      image_reg   <= 1'b0;
      act_reg     <= 1'b0;
      act_lat_reg <= 1'b0;
      mask_reg    <= 3'h0;
    end
    else
    begin
      if (out_last_out)
        frame_reg <= 1'b0;
      else if (start_w)
        frame_reg <= 1'b1;
      if (start_w)
        image_reg <= 1'b1;
      else if (pix_valid_in && pix_last_in)
        image_reg <= 1'b0;
      if (start_w)
        act_lat_reg <= act_reg;
      if (reg_wr_in && !acq_running_in && reg_addr_in == OFS_EXTRAS_ON)
        act_reg <= reg_wdata_in[0];
      if (reg_wr_in && reg_addr_in == OFS_IRQ_MASK)
        mask_reg <= reg_wdata_in[2:0];
    end
  end

  // ===
  // properties
  default clocking dc @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence image_end;
    pix_valid_in && pix_last_in && image_reg;
  endsequence

  a_rdata_quiet: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("read data outside read slot");
  a_image_echo: assert property (pix_valid_in && image_reg |=>
    out_valid_out && out_data_out == $past(pix_data_in))
    else $error("image word not passed on");
  a_plain_last: assert property (image_end ##0 !act_lat_reg |=> out_last_out)
    else $error("payload without extras not ended");
  a_extras_tail: assert property (image_end ##0 act_lat_reg |=>
    !out_last_out ##[1:40] out_last_out)
    else $error("extras tail missing or late");
  a_last_valid: assert property (out_last_out |-> out_valid_out)
    else $error("last without valid");
  a_valid_framed: assert property (out_valid_out |-> frame_reg)
    else $error("output word outside frame");
  a_active_read: assert property (reg_rd_in && reg_addr_in == OFS_EXTRAS_ON |=>
    reg_rdata_out == {31'h0, $past(act_reg)})
    else $error("activate reads wrong");
  a_forced_incl: assert property (reg_rd_in && reg_addr_in == OFS_INCLUDE_ALL |=>
    reg_rdata_out[1:0] == 2'b11 && reg_rdata_out[31:15] == 17'h0)
    else $error("forced includes not set");
  a_refuse_irq: assert property (reg_wr_in && acq_running_in &&
    reg_addr_in == OFS_EXTRAS_ON && mask_reg[IRQ_REFUSED_BIT] |-> ##[1:2] irq_out)
    else $error("refused write raised no interrupt");
endmodule

bind image_payload_metadata_appender payload_extras_chk u_chk (.*);
`default_nettype wire

// ==== testbench/payload_host_sink.sv ====
// host model: collects payload words, counts payloads
// assumes: the framer never waits for the host
`timescale 1ns/100ps
`default_nettype none
module payload_host_sink
(
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic        valid_in,
  input wire logic [31:0] data_in,
  input wire logic        last_in
);
  logic [31:0] words [$];
  int          frames;

  always @(posedge mclk_in)
  begin
    if (rst_n_in && valid_in)
    begin
      words.push_back(data_in);
      if (last_in)
        frames++;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/image_payload_metadata_appender_tb.sv ====
// testbench: register setup, payloads against a queue model, refusals
// assumes: package, framer and host sink compiled first
`timescale 1ns/100ps
`default_nettype none
module image_payload_metadata_appender_tb
  import payload_extras_pkg::*;
;
  logic        mclk;
  logic        rst_n = 1'b0;
  logic [5:0]  addr = '0;
  logic [31:0] wdata = '0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        acq = 1'b0;
  logic        pv = 1'b0;
  logic [31:0] pd = '0;
  logic        pl = 1'b0;
  logic [31:0] val [16] = '{default: '0};
  logic [31:0] amp [4] = '{default: '0};
  logic        ie = 1'b0;
  logic [3:0]  lines = '0;
  logic        sv = 1'b0;
  logic [7:0]  sb = '0;
  logic [31:0] rdata;
  logic        ov;
  logic [31:0] od;
  logic        ol;
  logic        irq;
  int          bad_count = 0;
  int          checks_done = 0;
  logic [14:0] inc = 15'h0003;
  logic        act = 1'b0;
  int          apick = 0;
  logic [31:0] img [$];
  logic [31:0] expq [$];
  logic [7:0]  ser [$];
  logic [3:0]  lexp;
  logic [31:0] d;

  image_payload_metadata_appender DUT
  (
    .mclk_in(mclk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .acq_running_in(acq),
    .pix_valid_in(pv), .pix_data_in(pd), .pix_last_in(pl), .frame_sequence_number_in(val[2]),
    .region_x_start_in(val[3]), .region_y_start_in(val[4]), .region_columns_in(val[5]),
    .region_rows_in(val[6]), .integration_duration_in(val[7]), .amp_all_in(amp[0]),
    .amp_red_in(amp[1]), .amp_green_in(amp[2]), .amp_blue_in(amp[3]),
    .dark_offset_value_in(val[9]), .sample_layout_code_in(val[10]),
    .capture_time_stamp_in(val[11]), .running_sequence_index_in(val[12]),
    .integration_end_in(ie), .io_lines_in(lines), .serial_valid_in(sv), .serial_byte_in(sb),
    .out_valid_out(ov), .out_data_out(od), .out_last_out(ol), .irq_out(irq)
  );

  payload_host_sink snk
  (
    .mclk_in(mclk), .rst_n_in(rst_n), .valid_in(ov), .data_in(od), .last_in(ol)
  );

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ===
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus_wr(input logic [ADDR_WIDTH-1:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [ADDR_WIDTH-1:0] a, output logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = rdata;
  endtask

  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] w);
    logic [31:0] r;
    r = c ^ w;
    for (int k = 0; k < 32; k++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction

  task automatic run_frame(input int ns);
    int          nw;
    int          f0;
    int          t;
    logic [31:0] crc;
    logic [7:0]  b;
    nw = ns + 2;
    f0 = snk.frames;
    img.delete();
    ser.delete();
    @(posedge mclk);
    acq <= 1'b1;
    for (int i = 0; i < 16; i++)
      val[i] <= $urandom();
    for (int i = 0; i < 4; i++)
      amp[i] <= $urandom();
    pv <= 1'b1;
    for (int i = 0; i < nw; i++)
    begin
      @(posedge mclk);
      img.push_back($urandom());
      pd <= img[i];
      pl <= (i == nw - 1);
      b = 8'($urandom());
      sb <= b;
      sv <= (i < ns);
      if (i < ns && ser.size() < SERIAL_DEPTH)
        ser.push_back(b);
      t = $urandom();
      lines <= 4'(t);
      ie <= (i == 0);
      if (i == 0)
        lexp = 4'(t);
    end
    @(posedge mclk);
    pv <= 1'b0;
    sv <= 1'b0;
    ie <= 1'b0;
    t = 0;
    while (snk.frames == f0 && t < 200)
    begin
      @(posedge mclk);
      t++;
    end
    acq <= 1'b0;
    crc = CRC_SEED;
    expq = img;
    foreach (img[i])
      crc = crc_word(crc, img[i]);
    if (act)
      for (int c = 1; c <= SEL_LAST; c++)
        if (inc[c])
          case (c)
            1: expq.push_back(crc ^ CRC_XOR_OUT);
            8: expq.push_back(amp[apick]);
            13:
            begin
              expq.push_back({ns > SERIAL_DEPTH, 26'h0, 5'(ser.size())});
              foreach (ser[j])
                expq.push_back({24'h0, ser[j]});
            end
            14: expq.push_back({28'h0, lexp});
            default: expq.push_back(val[c]);
          endcase
    chk("payload length", 32'(expq.size()), 32'(snk.words.size()));
    foreach (expq[i])
      chk("payload word", expq[i], snk.words[i]);
    snk.words.delete();
    bus_rd(OFS_LAST_FRAME, d);
    chk("last frame", val[2], d);
  endtask

  task conclude;
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #500000;
    bad_count++;
    conclude;
  end

  // ===
  // main sequence
  initial
  begin
    void'($urandom(12095));
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    bus_rd(OFS_EXTRAS_ON, d);
    chk("activate", 32'h0, d);
    bus_rd(OFS_INCLUDE_ALL, d);
    chk("includes", 32'h3, d);
    bus_rd(6'h3C, d);
    chk("unmapped", 32'h0, d);
    run_frame(3);
    bus_wr(OFS_INCLUDE_ALL, 32'h0);
    bus_rd(OFS_INCLUDE_ALL, d);
    chk("forced includes", 32'h3, d);
    for (int c = 0; c <= SEL_LAST; c++)
    begin
      bus_wr(OFS_BLOCK_PICK, 32'(c));
      bus_wr(OFS_BLOCK_INCLUDE, 32'(c % 2));
      inc[c] = (c < 2) || (c % 2 == 1);
      bus_rd(OFS_BLOCK_INCLUDE, d);
      chk("picked include", 32'(inc[c]), d);
    end
    bus_wr(OFS_EXTRAS_ON, 32'h1);
    act = 1'b1;
    run_frame(2);
    bus_wr(OFS_INCLUDE_ALL, 32'h7FFF);
    inc = 15'h7FFF;
    for (int p = 0; p < 4; p++)
    begin
      bus_wr(OFS_AMP_PICK, 32'(p));
      apick = p;
      run_frame(p * 6);
    end
    bus_wr(OFS_IRQ_MASK, 32'h2);
    @(posedge mclk);
    acq <= 1'b1;
    bus_wr(OFS_EXTRAS_ON, 32'h0);
    bus_wr(OFS_INCLUDE_ALL, 32'h3);
    bus_rd(OFS_EXTRAS_ON, d);
    chk("locked activate", 32'h1, d);
    bus_rd(OFS_INCLUDE_ALL, d);
    chk("locked includes", 32'h7FFF, d);
    chk("refusal interrupt", 32'h1, {31'h0, irq});
    bus_wr(OFS_IRQ_STATUS, 32'h2);
    repeat (2) @(posedge mclk);
    #1 chk("cleared interrupt", 32'h0, {31'h0, irq});
    conclude;
  end
endmodule
`default_nettype wire
